//--- asc_far_side.sv
// ball sensor and relay coil stand-in for the shut-off bench
`timescale 1ns/100ps
`default_nettype none
module asc_far_side (
    input  wire logic       clock,       // system clock
    input  wire logic [2:0] pos,         // ball position {up, level, down}
    input  wire logic       coil_in,     // relay drive
    output logic            sense_up,    // comparator up
    output logic            sense_level, // comparator middle
    output logic            sense_down,  // comparator down
    output logic [15:0]     coil_hi      // energised cycles, free running
);
    // a still ball gives steady comparators, so only the debounce delay shows
    assign {sense_up, sense_level, sense_down} = pos;
    initial coil_hi = 16'h0000;
    always @(posedge clock) coil_hi <= coil_hi + 16'(coil_in);
endmodule // asc_far_side
`default_nettype wire

//--- asc_shutoff.sv
// auto shut-off sequencer: start-up, heat-up, immobility timing and pulsed drivers
`timescale 1ns/100ps
`default_nettype none

module asc_shutoff #(
    parameter int TICK_CYC = asc_pkg::TICK_CYC_DEF,   // cycles per 100 us timing tick
    parameter int PWM_CYC  = asc_pkg::PWM_CYC_DEF     // cycles per switching period
) (
    input  wire logic       clock,                   // 125 MHz system clock
    input  wire logic       rst,                     // synchronous reset
    input  wire logic       supply_upper_threshold,  // supply above upper level
    input  wire logic       supply_lower_threshold,  // supply below lower level
    input  wire logic       sense_up,                // comparator: ball at up end
    input  wire logic       sense_level,             // comparator: ball in middle
    input  wire logic       sense_down,              // comparator: ball at down end
    input  wire logic       sensing_mode_sel,        // 0 position, 1 movement
    input  wire logic       warmup_hold_enable,      // 1 enables 90 s hold
    input  wire logic       phase_one_length_sel,    // 0 gives 0.5 s, 1 gives 3 s
    input  wire logic       drive_duty_sel_hi,       // duty select, upper bit
    input  wire logic       drive_duty_sel_lo,       // duty select, lower bit
    input  wire logic [2:0] version_sel,             // timing version minus one
    input  wire logic       relay_normally_open,     // normally-open relay variant
    input  wire logic [2:0] config_code_sel,         // third code frequency index
    output logic            shutoff_state,           // shut-off active
    output logic            relay_drive_out,         // pulsed coil drive
    output logic            indicator_drive_out,     // led drive
    output logic            device_in_reset          // sequencer held in reset
);
    typedef struct packed {
        asc_pkg::asc_state_type st;
        logic [15:0] tick_cnt;
        logic        tick;
        logic [23:0] phase_cnt;
        logic [7:0]  low_cnt;
        logic [7:0]  samp_cnt;
        logic [2:0]  samp1;
        logic [2:0]  samp2;
        logic [2:0]  stable;
        logic [23:0] idle_cnt;
        logic        shut;
        logic [23:0] shut_cnt;
        logic [7:0]  boost_cnt;
        logic [12:0] pwm_cnt;
        logic [12:0] half_cnt;
        logic [4:0]  dclk_cnt;
        logic        relay;
        logic        led;
    } asc_core_type;

    asc_core_type r, n;

    logic [1:0] supply_s;
    logic [2:0] pos_s;
    logic [1:0] duty_sel;
    logic       pos_change;
    logic       phase_done;
    logic [23:0] phase_len;
    logic [23:0] shut_delay;
    logic [23:0] blink_delay;
    logic [2:0]  pos_freq;
    logic [2:0]  cfg_freq;
    logic [12:0] duty_thr;
    logic        pwm_on;
    logic        blink_off;

    asc_sync3 #(.WIDTH(2)) u_supply_sync (
        .clock (clock),
        .rst   (rst),
        .d_in  ({supply_upper_threshold, supply_lower_threshold}),
        .q_out (supply_s)
    );

    asc_sync3 #(.WIDTH(3)) u_pos_sync (
        .clock (clock),
        .rst   (rst),
        .d_in  ({sense_up, sense_level, sense_down}),
        .q_out (pos_s)
    );

    assign duty_sel = {drive_duty_sel_hi, drive_duty_sel_lo};

    // shut-off delay for the held state; never means no shut-off
    always_comb begin
        shut_delay  = asc_pkg::N_NEVER;
        blink_delay = asc_pkg::N_ZERO;
        if (sensing_mode_sel) begin
            case (version_sel)
                3'h0: shut_delay = asc_pkg::N_30S;
                3'h1: begin
                    shut_delay  = asc_pkg::N_30S;
                    blink_delay = asc_pkg::N_4M;
                end
                3'h2: shut_delay = asc_pkg::N_4M;
                3'h3: shut_delay = asc_pkg::N_1M;
                3'h4: shut_delay = asc_pkg::N_10M;
                3'h5: shut_delay = asc_pkg::N_2M;
                3'h6: shut_delay = asc_pkg::N_8M;
                default: begin
                    shut_delay  = asc_pkg::N_30S;
                    blink_delay = asc_pkg::N_8M;
                end
            endcase
        end else begin
            // states between two comparators never time out
            case (r.stable)
                asc_pkg::POS_DOWN: shut_delay = asc_pkg::N_30S;
                asc_pkg::POS_LEVEL: begin
                    if (version_sel[1:0] == 2'h2) begin
                        shut_delay = asc_pkg::N_5S;
                    end else begin
                        shut_delay = asc_pkg::N_30S;
                    end
                end
                asc_pkg::POS_UP: begin
                    case (version_sel[1:0])
                        2'h0: shut_delay = asc_pkg::N_4M;
                        2'h1: shut_delay = asc_pkg::N_NEVER;
                        default: shut_delay = asc_pkg::N_8M;
                    endcase
                end
                default: shut_delay = asc_pkg::N_NEVER;
            endcase
        end
    end

    // length of the current start-up phase in ticks
    always_comb begin
        phase_len = asc_pkg::N_NEVER;
        case (r.st)
            asc_pkg::ST_PH0: phase_len = asc_pkg::N_PH0;
            asc_pkg::ST_PH1: begin
                if (phase_one_length_sel) begin
                    phase_len = asc_pkg::N_PH1_LONG;
                end else begin
                    phase_len = asc_pkg::N_PH1_SHORT;
                end
            end
            asc_pkg::ST_PH2: begin
                if (relay_normally_open) begin
                    phase_len = asc_pkg::N_PH2_NO;
                end else begin
                    phase_len = asc_pkg::N_PH2;
                end
            end
            asc_pkg::ST_WARM: phase_len = asc_pkg::N_WARM;
            default: phase_len = asc_pkg::N_NEVER;
        endcase
    end

    assign phase_done = r.tick && (r.phase_cnt >= phase_len - 24'h000001);

    // diagnostic divider index: each step halves 20.48 kHz
    always_comb begin
        case (r.stable)
            asc_pkg::POS_UP:       pos_freq = 3'h4;
            asc_pkg::POS_UP_LEVEL: pos_freq = 3'h3;
            asc_pkg::POS_LEVEL:    pos_freq = 3'h2;
            asc_pkg::POS_LEVEL_DN: pos_freq = 3'h1;
            asc_pkg::POS_DOWN:     pos_freq = 3'h0;
            default:               pos_freq = 3'h2;
        endcase
        if (config_code_sel > 3'h4) begin
            cfg_freq = 3'h4;
        end else begin
            cfg_freq = config_code_sel;
        end
    end

    // duty threshold within one switching period
    always_comb begin
        if (r.boost_cnt != 8'h00) begin
            duty_thr = 13'((PWM_CYC * asc_pkg::BOOST_PM[duty_sel]) / 1000);
        end else begin
            duty_thr = 13'((PWM_CYC * asc_pkg::DUTY_PM[duty_sel]) / 1000);
        end
    end

    assign pwm_on = r.pwm_cnt < duty_thr;

    // upright blinking in movement mode once the blink delay has run
    assign blink_off = sensing_mode_sel && (r.stable == asc_pkg::POS_UP)
                     && (r.shut_cnt >= blink_delay) && r.shut_cnt[asc_pkg::BLINK_BIT];

    always_comb begin
        n            = r;
        n.tick       = 1'b0;
        pos_change   = 1'b0;

        if (r.tick_cnt >= 16'(TICK_CYC - 1)) begin
            n.tick_cnt = 16'h0000;
            n.tick     = 1'b1;
        end else begin
            n.tick_cnt = r.tick_cnt + 16'h0001;
        end

        if (r.pwm_cnt >= 13'(PWM_CYC - 1)) begin
            n.pwm_cnt = 13'h0000;
        end else begin
            n.pwm_cnt = r.pwm_cnt + 13'h0001;
        end

        if (r.half_cnt >= 13'(PWM_CYC / 2 - 1)) begin
            n.half_cnt = 13'h0000;
            n.dclk_cnt = r.dclk_cnt + 5'h01;
        end else begin
            n.half_cnt = r.half_cnt + 13'h0001;
        end

        // supply back above the lower level clears the count, so only a long sag trips reset
        if (!supply_s[0]) begin
            n.low_cnt = 8'h00;
        end else if (r.tick && (r.low_cnt != 8'hFF)) begin
            n.low_cnt = r.low_cnt + 8'h01;
        end

        if (r.tick) begin
            n.phase_cnt = r.phase_cnt + 24'h000001;
            if (r.samp_cnt >= asc_pkg::N_SAMPLE - 8'h01) begin
                n.samp_cnt = 8'h00;
                n.samp1    = pos_s;
                n.samp2    = r.samp1;
                if ((pos_s == r.samp1) && (r.samp1 == r.samp2) && (pos_s != r.stable)) begin
                    n.stable   = pos_s;
                    pos_change = 1'b1;
                end
            end else begin
                n.samp_cnt = r.samp_cnt + 8'h01;
            end
        end

        case (r.st)
            asc_pkg::ST_RESET: begin
                n.shut = 1'b0;
                if (supply_s[1]) begin
                    n.st        = asc_pkg::ST_PH0;
                    n.phase_cnt = 24'h000000;
                end
            end
            asc_pkg::ST_PH0: begin
                n.shut = 1'b0;
                if (phase_done) begin
                    n.st        = asc_pkg::ST_PH1;
                    n.phase_cnt = 24'h000000;
                end
            end
            asc_pkg::ST_PH1: begin
                n.shut = 1'b0;
                if (phase_done) begin
                    n.st        = asc_pkg::ST_PH2;
                    n.phase_cnt = 24'h000000;
                end
            end
            asc_pkg::ST_PH2: begin
                n.shut = 1'b1;
                if (phase_done) begin
                    n.shut      = 1'b0;
                    n.idle_cnt  = 24'h000000;
                    n.phase_cnt = 24'h000000;
                    if (warmup_hold_enable) begin
                        n.st = asc_pkg::ST_WARM;
                    end else begin
                        n.st = asc_pkg::ST_RUN;
                    end
                end
            end
            asc_pkg::ST_WARM: begin
                n.shut = 1'b0;
                if (phase_done) begin
                    n.st       = asc_pkg::ST_RUN;
                    n.idle_cnt = 24'h000000;
                end
            end
            asc_pkg::ST_RUN: begin
                if (pos_change) begin
                    n.idle_cnt = 24'h000000;
                    n.shut     = 1'b0;
                end else begin
                    if (r.tick && (r.idle_cnt != asc_pkg::N_NEVER)) begin
                        n.idle_cnt = r.idle_cnt + 24'h000001;
                    end
                    if (!r.shut && (shut_delay != asc_pkg::N_NEVER) && (r.idle_cnt >= shut_delay)) begin
                        n.shut     = 1'b1;
                        n.shut_cnt = 24'h000000;
                    end
                end
                if (r.shut && r.tick && (r.shut_cnt != asc_pkg::N_NEVER)) begin
                    n.shut_cnt = r.shut_cnt + 24'h000001;
                end
            end
            default: begin
                n.st   = asc_pkg::ST_RESET;
                n.shut = 1'b0;
            end
        endcase

        if ((r.st != asc_pkg::ST_RESET) && (r.low_cnt > asc_pkg::N_LOW)) begin
            n.st   = asc_pkg::ST_RESET;
            n.shut = 1'b0;
        end

        // boost window starts when the shut-off state is entered
        if (n.shut && !r.shut) begin
            n.boost_cnt = asc_pkg::N_BOOST;
        end else if (!r.shut) begin
            n.boost_cnt = 8'h00;
        end else if (r.tick && (r.boost_cnt != 8'h00)) begin
            n.boost_cnt = r.boost_cnt - 8'h01;
        end

        n.relay = r.shut && pwm_on;

        case (r.st)
            asc_pkg::ST_PH2: begin
                if (r.phase_cnt < asc_pkg::N_CODE) begin
                    n.led = r.dclk_cnt[0];
                end else if ((r.phase_cnt < asc_pkg::N_CODE + asc_pkg::N_CODE) || relay_normally_open) begin
                    n.led = r.dclk_cnt[pos_freq];
                end else begin
                    n.led = r.dclk_cnt[cfg_freq];
                end
            end
            asc_pkg::ST_RUN: n.led = r.shut && pwm_on && !blink_off;
            default: n.led = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r <= '{st: asc_pkg::ST_RESET, default: '0};
        end else begin
            r <= n;
        end
    end

    assign shutoff_state       = r.shut;
    assign relay_drive_out     = r.relay;
    assign indicator_drive_out = r.led;
    assign device_in_reset     = (r.st == asc_pkg::ST_RESET);
endmodule // asc_shutoff

`default_nettype wire

//--- asc_shutoff_bench.sv
// self-checking bench for the auto shut-off sequencer
`timescale 1ns/100ps
`default_nettype none
module asc_shutoff_bench;
    localparam int TICK = 4;
    localparam int PWM  = 64;
    logic        clock = 1'b0, rst = 1'b1, sup_hi = 1'b0, sup_lo = 1'b0, s_up, s_lv, s_dn;
    logic        shut, relay, led, in_rst;
    logic        duty_hi = 1'b0, duty_lo = 1'b1;
    logic [2:0]  ver = 3'h0;
    logic [2:0]  pos = asc_pkg::POS_LEVEL;
    logic [15:0] coil_hi;
    int          err_count = 0, total_checks = 0, cyc = 0, t0 = 0;
    always #4 clock = ~clock;
    // duty code 01, short phase one, open-relay variant keep the run short
    asc_shutoff #(.TICK_CYC(TICK), .PWM_CYC(PWM)) asc_shutoff_inst (.clock(clock), .rst(rst),
        .supply_upper_threshold(sup_hi), .supply_lower_threshold(sup_lo), .sense_up(s_up),
        .sense_level(s_lv), .sense_down(s_dn), .sensing_mode_sel(1'b0), .warmup_hold_enable(1'b0),
        .phase_one_length_sel(1'b0), .drive_duty_sel_hi(duty_hi), .drive_duty_sel_lo(duty_lo),
        .version_sel(ver), .relay_normally_open(1'b1), .config_code_sel(3'h2), .shutoff_state(shut),
        .relay_drive_out(relay), .indicator_drive_out(led), .device_in_reset(in_rst));
    asc_far_side asc_far_side_inst (.clock(clock), .pos(pos), .coil_in(relay), .sense_up(s_up),
        .sense_level(s_lv), .sense_down(s_dn), .coil_hi(coil_hi));
    task automatic final_report;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic chk_rng(input string what, input int lo, input int hi, input logic [15:0] got);
        total_checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            err_count++;
            $display("Error %s expected %0d to %0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic to(input int t);
        while (cyc < t) @(negedge clock);
    endtask
    // coil-on cycles over three whole periods, started on a pulse edge
    task automatic duty(input string what, input logic [15:0] exp);
        logic [15:0] h0;
        wait (relay === 1'b0);
        @(posedge relay);
        @(negedge clock);
        h0 = coil_hi;
        repeat (3 * PWM) @(negedge clock);
        chk(what, exp, coil_hi - h0);
    endtask
    task automatic led_rises(input string what, input int win);
        int   r;
        logic p;
        r = 0;
        p = led;
        repeat (win) begin
            @(negedge clock);
            r += int'(led === 1'b1 && p === 1'b0);
            p = led;
        end
        chk_rng(what, 9, 11, 16'(r));
    endtask
    task automatic t_startup;
        sup_hi = 1'b1;
        t0 = cyc;
        while (in_rst !== 1'b0 && cyc < t0 + 20) @(negedge clock);
        chk_rng("reset release", 2, 8, 16'(cyc - t0));
        t0 = cyc;
        to(t0 + 12000);
        sup_lo = 1'b1;
        to(cyc + 70 * TICK);
        sup_lo = 1'b0;
        to(cyc + 10);
        chk("reset after dip", 16'h0000, 16'(in_rst));
        chk("led phase one", 16'h0000, 16'(led));
        while (shut !== 1'b1 && cyc < t0 + 30000) @(negedge clock);
        chk_rng("start length", 6995 * TICK, 7015 * TICK, 16'(cyc - t0));
    endtask
    task automatic t_phase_two;
        t0 = cyc;
        duty("boost duty", 16'(3 * (PWM * 430 / 1000)));
        to(t0 + 600);
        duty("steady duty", 16'(3 * (PWM * 280 / 1000)));
        to(t0 + 1000);
        led_rises("first code", 10 * PWM);
        to(t0 + 2500 * TICK + 300);
        led_rises("position code", 40 * PWM);
        // three samples 156 ticks apart must agree before the code follows the ball
        pos = asc_pkg::POS_DOWN;
        to(cyc + 2100);
        led_rises("down code", 10 * PWM);
        while (shut === 1'b1 && cyc < t0 + 21000) @(negedge clock);
        chk_rng("phase two length", 4995 * TICK, 5015 * TICK, 16'(cyc - t0));
        to(cyc + 4);
        chk("coil after shut-off", 16'h0000, 16'(relay));
    endtask
    task automatic t_sag;
        sup_lo = 1'b1;
        sup_hi = 1'b0;
        to(cyc + 100 * TICK);
        chk("reset on long sag", 16'h0001, 16'(in_rst));
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            final_report;
        end
    end
    initial begin
        repeat (2) @(negedge clock);
        rst = 1'b0;
        t_startup;
        t_phase_two;
        t_sag;
        final_report;
    end
endmodule // asc_shutoff_bench
bind asc_shutoff asc_shutoff_props #(.TICK_CYC(TICK_CYC), .PWM_CYC(PWM_CYC)) asc_shutoff_props_inst (
    .clock(clock), .rst(rst), .supply_upper_threshold(supply_upper_threshold),
    .supply_lower_threshold(supply_lower_threshold), .phase_one_length_sel(phase_one_length_sel),
    .relay_normally_open(relay_normally_open), .shutoff_state(shutoff_state), .relay_drive_out(relay_drive_out),
    .indicator_drive_out(indicator_drive_out), .device_in_reset(device_in_reset));
`default_nettype wire

//--- asc_shutoff_props.sv
// port-level timing and drive checks for the shut-off sequencer
`timescale 1ns/100ps
`default_nettype none
module asc_shutoff_props #(
    parameter int TICK_CYC = 4,  // cycles per tick
    parameter int PWM_CYC  = 64  // cycles per period
) (
    input wire logic clock,                  // clock
    input wire logic rst,                    // reset
    input wire logic supply_upper_threshold, // supply up
    input wire logic supply_lower_threshold, // supply sag
    input wire logic phase_one_length_sel,   // phase one length
    input wire logic relay_normally_open,    // open variant
    input wire logic shutoff_state,          // shut-off
    input wire logic relay_drive_out,        // coil drive
    input wire logic indicator_drive_out,    // led
    input wire logic device_in_reset         // in reset
);
    localparam int SAG_MIN = 78 * TICK_CYC - 8;
    localparam int SAG_MAX = 80 * TICK_CYC + 8;
    localparam int HI_MAX  = PWM_CYC * 480 / 1000 + 1;
    logic [15:0] sag_cnt, hi_cnt, gap_cnt;
    logic [23:0] up_cnt;
    logic        relay_q, gap_arm, gap_ok, rise;
    assign rise = relay_drive_out && !relay_q;
    always_ff @(posedge clock) begin
        sag_cnt <= supply_lower_threshold ? sag_cnt + 16'(sag_cnt != 16'hFFFF) : 16'h0000;
        up_cnt  <= device_in_reset ? 24'h000000 : up_cnt + 24'(up_cnt != 24'hFFFFFF);
        hi_cnt  <= relay_drive_out ? hi_cnt + 16'h0001 : 16'h0000;
        gap_cnt <= rise ? 16'h0001 : gap_cnt + 16'h0001;
        relay_q <= relay_drive_out;
        // first pulse after shut-off may start mid-window, so periods are timed from the second
        gap_arm <= shutoff_state && (rise || gap_arm);
        gap_ok  <= shutoff_state && ((rise && gap_arm) || gap_ok);
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    hold_reset_a: assert property ((device_in_reset && !supply_upper_threshold) [*5] |=> device_in_reset)
        else $error("reset left without supply");
    reset_quiet_a: assert property (device_in_reset && $past(device_in_reset) |->
        !shutoff_state && !relay_drive_out && !indicator_drive_out) else $error("output active in reset");
    sag_ignore_a: assert property ($rose(device_in_reset) |-> sag_cnt >= SAG_MIN)
        else $error("reset on short sag");
    sag_reset_a: assert property (sag_cnt == SAG_MAX |-> device_in_reset)
        else $error("long sag missed");
    coil_shut_a: assert property (relay_drive_out |-> shutoff_state || $past(shutoff_state))
        else $error("coil driven outside shut-off");
    early_quiet_a: assert property (up_cnt < 6990 * TICK_CYC |-> !shutoff_state)
        else $error("shut-off before phase two");
    led_dark_a: assert property (up_cnt >= 2010 * TICK_CYC && up_cnt < 6990 * TICK_CYC |->
        !indicator_drive_out) else $error("led lit in phase one");
    ph2_shut_a: assert property (!phase_one_length_sel && up_cnt >= 7010 * TICK_CYC &&
        up_cnt < 11990 * TICK_CYC |-> shutoff_state) else $error("shut-off absent in phase two");
    ph2_short_a: assert property (relay_normally_open && !phase_one_length_sel &&
        up_cnt >= 12010 * TICK_CYC && up_cnt < 13000 * TICK_CYC |-> !shutoff_state) else $error("phase two too long");
    duty_cap_a: assert property (hi_cnt <= HI_MAX)
        else $error("coil pulse too wide");
    pwm_period_a: assert property (rise && gap_ok |-> gap_cnt == PWM_CYC)
        else $error("switching period wrong");
endmodule // asc_shutoff_props
`default_nettype wire

//--- asc_sync3.sv
// shut-off sequencer constants and the three-stage input synchroniser
`timescale 1ns/100ps
`default_nettype none
package asc_pkg;
    localparam int CLK_HZ        = 125_000_000;
    localparam int DCLK_HZ       = 20_480;
    localparam int TICK_US       = 100;
    localparam int TICK_CYC_DEF  = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int PWM_CYC_DEF   = CLK_HZ / DCLK_HZ;

    localparam int T_LOW_US      = 7_800;
    localparam int T_BOOST_US    = 7_800;
    localparam int T_SAMPLE_US   = 15_600;
    localparam int T_PH0_US      = 200_000;
    localparam int T_PH1_SHORT_US = 500_000;
    localparam int T_PH1_LONG_US = 3_000_000;
    localparam int T_PH2_US      = 750_000;
    localparam int T_PH2_NO_US   = 500_000;
    localparam int T_CODE_US     = 250_000;
    localparam int T_WARM_US     = 90_000_000;
    localparam int T_5S_US       = 5_000_000;
    localparam int T_30S_US      = 30_000_000;
    localparam int T_1M_US       = 60_000_000;
    localparam int T_2M_US       = 120_000_000;
    localparam int T_4M_US       = 240_000_000;
    localparam int T_8M_US       = 480_000_000;
    localparam int T_10M_US      = 600_000_000;

    localparam logic [7:0]  N_LOW       = 8'(T_LOW_US / TICK_US);
    localparam logic [7:0]  N_BOOST     = 8'(T_BOOST_US / TICK_US);
    localparam logic [7:0]  N_SAMPLE    = 8'(T_SAMPLE_US / TICK_US);
    localparam logic [23:0] N_PH0       = 24'(T_PH0_US / TICK_US);
    localparam logic [23:0] N_PH1_SHORT = 24'(T_PH1_SHORT_US / TICK_US);
    localparam logic [23:0] N_PH1_LONG  = 24'(T_PH1_LONG_US / TICK_US);
    localparam logic [23:0] N_PH2       = 24'(T_PH2_US / TICK_US);
    localparam logic [23:0] N_PH2_NO    = 24'(T_PH2_NO_US / TICK_US);
    localparam logic [23:0] N_CODE      = 24'(T_CODE_US / TICK_US);
    localparam logic [23:0] N_WARM      = 24'(T_WARM_US / TICK_US);
    localparam logic [23:0] N_5S        = 24'(T_5S_US / TICK_US);
    localparam logic [23:0] N_30S       = 24'(T_30S_US / TICK_US);
    localparam logic [23:0] N_1M        = 24'(T_1M_US / TICK_US);
    localparam logic [23:0] N_2M        = 24'(T_2M_US / TICK_US);
    localparam logic [23:0] N_4M        = 24'(T_4M_US / TICK_US);
    localparam logic [23:0] N_8M        = 24'(T_8M_US / TICK_US);
    localparam logic [23:0] N_10M       = 24'(T_10M_US / TICK_US);
    localparam logic [23:0] N_NEVER     = 24'hFFFFFF;
    localparam logic [23:0] N_ZERO      = 24'h000000;

    // blink half period is 2^12 ticks, about 0.41 s
    localparam int BLINK_BIT = 12;

    // duty cycles in per-mille, indexed by {drive_duty_sel_hi, drive_duty_sel_lo}
    localparam int DUTY_PM  [4] = '{144, 280, 160, 310};
    localparam int BOOST_PM [4] = '{280, 430, 310, 480};

    // debounced position codes {up, level, down}
    localparam logic [2:0] POS_UP       = 3'h4;
    localparam logic [2:0] POS_UP_LEVEL = 3'h6;
    localparam logic [2:0] POS_LEVEL    = 3'h2;
    localparam logic [2:0] POS_LEVEL_DN = 3'h3;
    localparam logic [2:0] POS_DOWN     = 3'h1;

    typedef enum logic [5:0] {
        ST_RESET = 6'h01,
        ST_PH0   = 6'h02,
        ST_PH1   = 6'h04,
        ST_PH2   = 6'h08,
        ST_WARM  = 6'h10,
        ST_RUN   = 6'h20
    } asc_state_type;
endpackage

module asc_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,   // system clock
    input  wire logic             rst,     // synchronous reset
    input  wire logic [WIDTH-1:0] d_in,    // asynchronous input
    output logic      [WIDTH-1:0] q_out    // filtered synchronous copy
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } asc_sync_type;

    asc_sync_type r, n;

    always_comb begin
        n    = r;
        n.s1 = d_in;
        n.s2 = r.s1;
        n.s3 = r.s2;
        // only a level seen by both later stages counts
        for (int i = 0; i < WIDTH; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                n.q[i] = r.s3[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q_out = r.q;
endmodule // asc_sync3

`default_nettype wire
